/* hw/pxsc_pkg.sv */
// package: register layout, field positions and types for the crossover control
package pxsc_pkg;

    localparam logic [4:0]  PXSC_REG_INDEX     = 5'h1b;
    localparam int          PXSC_DATA_W        = 16;
    localparam int          PXSC_BIT_SRC_SEL   = 15;
    localparam int          PXSC_BIT_AUTO_EN   = 14;
    localparam int          PXSC_BIT_MAN_STATE = 13;
    localparam int          PXSC_BIT_HB_DIS    = 11;
    localparam int          PXSC_BIT_PLL_REF   = 10;
    localparam int          PXSC_BIT_POL_REV   = 4;
    localparam logic [15:0] PXSC_RESET_VALUE   = 16'h0000;
    localparam logic [15:0] PXSC_WRITE_MASK    = 16'hec00;
    localparam int          PXSC_NUM_PORTS     = 2;

    // crossover modes, gray order along straight -> crossover -> auto
    typedef enum logic [1:0] {
        PXSC_MODE_STRAIGHT = 2'h0,
        PXSC_MODE_CROSS    = 2'h1,
        PXSC_MODE_AUTO     = 2'h3,
        PXSC_MODE_RSVD     = 2'h2
    } pxsc_mode_e;

    // writable control fields of one port
    typedef struct packed {
        logic src_sel;
        logic auto_en;
        logic man_state;
        logic hb_dis;
        logic pll_ref;
    } pxsc_ctrl_s;

    // register access request from the management interface
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  index;
        logic [15:0] wdata;
    } pxsc_req_s;

endpackage : pxsc_pkg

/* hw/pxsc_sync.sv */
// two-flop synchroniser for one bit
module pxsc_sync (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    input  wire logic clk_en_in,
    // data
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            q_out  <= 1'b0;
        end else if (clk_en_in) begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule // pxsc_sync

/* hw/pxsc_top.sv */
// per-port crossover special control and indication register
//
// Notes on behaviour
// - Source select set: straps ignored, register bits pick crossover.
// - Source select clear (default): the latched straps pick crossover.
// - Register mode: enable,state 0,0 straight, 0,1 cross, 1,0 automatic.
// - Strap mode: automatic strap wins, else manual strap picks cross.
// - Heartbeat test runs while bit 11 is zero, suppressed while one.
// - While bit 10 is one the 10M receive PLL locks to the reference.
// - While the PLL is forced to reference no 10 Mb/s packet is received.
// - Bit 4 reads the 10BASE-T receive polarity, one reversed, reset zero.
// - Writable control bits clear on a port PHY reset from reset control.
// - That clearing applies only while the basic control PHY reset is set.
// - Latched automatic straps of both ports show in the hardware config.
module pxsc_top
    import pxsc_pkg::*;
#(
    parameter int PORT_SEL = 0
) (
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              clk_en_in,
    // management register access
    input  wire pxsc_req_s         req_in,
    output logic [PXSC_DATA_W-1:0] rdata_out,
    output logic                   rdata_valid_out,
    // port phy reset from chip reset control, qualified by basic control
    input  wire logic              port_phy_reset_in,
    input  wire logic              basic_ctrl_phy_rst_in,
    // latched straps of both ports
    input  wire logic [1:0]        auto_strap_in,
    input  wire logic [1:0]        manual_strap_in,
    // polarity detector, asynchronous to this clock
    input  wire logic              polarity_reversed_in,
    // 10M receive data valid from the line
    input  wire logic              rx10_valid_in,
    // decoded controls towards the phy
    output pxsc_mode_e             crossover_mode_out,
    output logic                   heartbeat_test_enable_out,
    output logic                   rx_pll_force_reference_out,
    output logic                   rx10_valid_out,
    // strap state bits for the hardware config register
    output logic [1:0]             hardware_config_register_auto_strap_out
);

    ////////////////////////////////////////////////////////////////////////
    // state

    pxsc_ctrl_s ctrl_q;
    pxsc_ctrl_s ctrl_d;
    logic       pol_sync;
    logic       pol_q;
    logic       hit;
    logic       do_write;
    logic       phy_clear;
    logic       own_auto;
    logic       own_manual;
    pxsc_mode_e reg_mode;
    pxsc_mode_e strap_mode;
    logic [PXSC_DATA_W-1:0] reg_value;
    logic [PXSC_DATA_W-1:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // polarity input crossing

    pxsc_sync u_pol_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .clk_en_in  (clk_en_in),
        .d_in       (polarity_reversed_in),
        .q_out      (pol_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // register decode and write

    assign hit       = (req_in.index == PXSC_REG_INDEX);
    assign do_write  = req_in.wr && hit;
    assign phy_clear = port_phy_reset_in && basic_ctrl_phy_rst_in;

    always_comb begin
        ctrl_d = ctrl_q;
        if (phy_clear) begin
            ctrl_d = '0;
        end else if (do_write) begin
            // only the writable positions are taken
            ctrl_d.src_sel   = req_in.wdata[PXSC_BIT_SRC_SEL];
            ctrl_d.auto_en   = req_in.wdata[PXSC_BIT_AUTO_EN];
            ctrl_d.man_state = req_in.wdata[PXSC_BIT_MAN_STATE];
            ctrl_d.hb_dis    = req_in.wdata[PXSC_BIT_HB_DIS];
            ctrl_d.pll_ref   = req_in.wdata[PXSC_BIT_PLL_REF];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= '0;
            pol_q  <= 1'b0;
        end else if (clk_en_in) begin
            ctrl_q <= ctrl_d;
            pol_q  <= pol_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        reg_value                     = '0;
        reg_value[PXSC_BIT_SRC_SEL]   = ctrl_q.src_sel;
        reg_value[PXSC_BIT_AUTO_EN]   = ctrl_q.auto_en;
        reg_value[PXSC_BIT_MAN_STATE] = ctrl_q.man_state;
        reg_value[PXSC_BIT_HB_DIS]    = ctrl_q.hb_dis;
        reg_value[PXSC_BIT_PLL_REF]   = ctrl_q.pll_ref;
        reg_value[PXSC_BIT_POL_REV]   = pol_q;
    end

    assign rdata_d = (req_in.rd && hit) ? reg_value : '0;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out       <= '0;
            rdata_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            rdata_out       <= rdata_d;
            rdata_valid_out <= req_in.rd && hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossover decode

    function automatic pxsc_mode_e pxsc_decode(input logic auto_bit,
                                               input logic cross_bit);
        pxsc_mode_e m;
        m = PXSC_MODE_STRAIGHT;
        if (auto_bit) begin
            m = PXSC_MODE_AUTO;
        end else if (cross_bit) begin
            m = PXSC_MODE_CROSS;
        end
        return m;
    endfunction

    assign own_auto   = auto_strap_in[PORT_SEL];
    assign own_manual = manual_strap_in[PORT_SEL];
    // reserved 1,1 pair falls to automatic; software must avoid it
    assign reg_mode   = pxsc_decode(ctrl_q.auto_en, ctrl_q.man_state);
    assign strap_mode = pxsc_decode(own_auto, own_manual);

    assign crossover_mode_out = ctrl_q.src_sel ? reg_mode
                                               : strap_mode;

    ////////////////////////////////////////////////////////////////////////
    // 10M controls

    assign heartbeat_test_enable_out  = !ctrl_q.hb_dis;
    assign rx_pll_force_reference_out = ctrl_q.pll_ref;
    assign rx10_valid_out = rx10_valid_in && !ctrl_q.pll_ref;
    assign hardware_config_register_auto_strap_out      = auto_strap_in;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_src_reg;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ctrl_q.src_sel && ctrl_q.auto_en && !ctrl_q.man_state |->
            crossover_mode_out == PXSC_MODE_AUTO;
    endproperty
    a_src_reg: assert property (p_src_reg)
        else $error("register mode not followed");

    property p_src_strap;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !ctrl_q.src_sel && own_auto |-> crossover_mode_out == PXSC_MODE_AUTO;
    endproperty
    a_src_strap: assert property (p_src_strap)
        else $error("auto strap not honoured");

    property p_strap_manual;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !ctrl_q.src_sel && !own_auto |->
            crossover_mode_out == (own_manual ? PXSC_MODE_CROSS
                                              : PXSC_MODE_STRAIGHT);
    endproperty
    a_strap_manual: assert property (p_strap_manual)
        else $error("manual strap not honoured");

    property p_reg_decode;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ctrl_q.src_sel && !ctrl_q.auto_en |->
            crossover_mode_out == (ctrl_q.man_state ? PXSC_MODE_CROSS
                                                    : PXSC_MODE_STRAIGHT);
    endproperty
    a_reg_decode: assert property (p_reg_decode)
        else $error("manual register decode wrong");

    property p_heartbeat;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && do_write && !phy_clear ##1 1'b1 |->
            heartbeat_test_enable_out != $past(req_in.wdata[PXSC_BIT_HB_DIS]);
    endproperty
    a_heartbeat: assert property (p_heartbeat)
        else $error("heartbeat disable not taken");

    property p_pll_block;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        rx_pll_force_reference_out |-> !rx10_valid_out;
    endproperty
    a_pll_block: assert property (p_pll_block)
        else $error("10M data passed while pll forced");

    property p_pll_force;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && do_write && !phy_clear |=>
            rx_pll_force_reference_out == $past(req_in.wdata[PXSC_BIT_PLL_REF]);
    endproperty
    a_pll_force: assert property (p_pll_force)
        else $error("pll force bit not taken");

    property p_phy_clear;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && phy_clear |=> ctrl_q == '0;
    endproperty
    a_phy_clear: assert property (p_phy_clear)
        else $error("phy reset did not clear controls");

    property p_phy_qual;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        port_phy_reset_in && !basic_ctrl_phy_rst_in && !do_write |=>
            ctrl_q == $past(ctrl_q);
    endproperty
    a_phy_qual: assert property (p_phy_qual)
        else $error("unqualified phy reset changed controls");

    property p_reserved;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        rdata_valid_out |-> (rdata_out & ~(PXSC_WRITE_MASK
            | (16'h0001 << PXSC_BIT_POL_REV))) == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit read nonzero");

    property p_polarity;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && req_in.rd && hit |=>
            rdata_out[PXSC_BIT_POL_REV] == $past(pol_q);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity bit mismatch");

    property p_pol_track;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in |=> pol_q == $past(pol_sync);
    endproperty
    a_pol_track: assert property (p_pol_track)
        else $error("polarity register not following");

    property p_write_fields;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && do_write && !phy_clear |=>
            ctrl_q.src_sel == $past(req_in.wdata[PXSC_BIT_SRC_SEL]) &&
            ctrl_q.auto_en == $past(req_in.wdata[PXSC_BIT_AUTO_EN]) &&
            ctrl_q.man_state == $past(req_in.wdata[PXSC_BIT_MAN_STATE]);
    endproperty
    a_write_fields: assert property (p_write_fields)
        else $error("crossover fields not taken");

    property p_other_index;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && req_in.wr && !hit && !phy_clear |=>
            ctrl_q == $past(ctrl_q);
    endproperty
    a_other_index: assert property (p_other_index)
        else $error("write to another index changed controls");

    property p_read_idle;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && !(req_in.rd && hit) |=>
            !rdata_valid_out && rdata_out == '0;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read answer without a read");

    property p_pll_free;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !rx_pll_force_reference_out |-> rx10_valid_out == rx10_valid_in;
    endproperty
    a_pll_free: assert property (p_pll_free)
        else $error("10M data dropped while pll free");

    // a low clock enable holds the control, polarity and read valid registers
    property p_freeze;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !clk_en_in |=> ctrl_q == $past(ctrl_q) && pol_q == $past(pol_q) &&
            rdata_valid_out == $past(rdata_valid_out);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");

    property p_strap_cfg;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        hardware_config_register_auto_strap_out == auto_strap_in;
    endproperty
    a_strap_cfg: assert property (p_strap_cfg)
        else $error("strap state not exposed");

endmodule // pxsc_top

/* dv/pxsc_host_model.sv */
// management host model: single register reads and writes
module pxsc_host_model
    import pxsc_pkg::*;
(
    // clock
    input  wire logic        clk_in,
    // register access
    output pxsc_req_s        req_out,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rdata_valid_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req_out = '0;

    ////////////////////////////////////////////////////////////////////////
    task automatic write_reg(input logic [4:0] idx, input logic [15:0] d);
        @(negedge clk_in);
        // the reserved enable/state pair is never sent
        d[13] = d[13] & ~d[14];
        req_out <= '{1'b1, 1'b0, idx, d};
        @(negedge clk_in);
        req_out <= '{1'b0, 1'b0, ~idx, ~d};
    endtask

    task automatic read_reg(input logic [4:0] idx, output logic [15:0] d,
                            output logic v);
        @(negedge clk_in);
        req_out <= '{1'b0, 1'b1, idx, ~req_out.wdata};
        @(negedge clk_in);
        d = rdata_in;
        v = rdata_valid_in;
        req_out <= '{1'b0, 1'b0, ~idx, req_out.wdata};
    endtask
endmodule // pxsc_host_model

/* dv/pxsc_top_bench.sv */
// testbench for the crossover special control register
module pxsc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pxsc_pkg::*;

    logic        clk, rst_n, en, port_rst, basic_rst, pol, rx10;
    logic [1:0]  auto_s, man_s, hwcfg;
    pxsc_req_s   req;
    logic [15:0] rdata, w;
    logic        rvalid, hb_en, pll, rx10_o;
    pxsc_mode_e  mode;
    int          failures, n_checks, cycles, seed;

    pxsc_top #(.PORT_SEL(1)) i_dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(en),
        .req_in(req), .rdata_out(rdata), .rdata_valid_out(rvalid),
        .port_phy_reset_in(port_rst), .basic_ctrl_phy_rst_in(basic_rst),
        .auto_strap_in(auto_s), .manual_strap_in(man_s),
        .polarity_reversed_in(pol), .rx10_valid_in(rx10),
        .crossover_mode_out(mode), .heartbeat_test_enable_out(hb_en),
        .rx_pll_force_reference_out(pll), .rx10_valid_out(rx10_o),
        .hardware_config_register_auto_strap_out(hwcfg));

    pxsc_host_model i_host (.clk_in(clk), .req_out(req),
        .rdata_in(rdata), .rdata_valid_in(rvalid));

    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    function automatic pxsc_mode_e exp_mode(input logic [15:0] r,
                                            input logic a, input logic m);
        if (r[PXSC_BIT_SRC_SEL])
            return r[PXSC_BIT_AUTO_EN] ? PXSC_MODE_AUTO :
                   (r[PXSC_BIT_MAN_STATE] ? PXSC_MODE_CROSS
                                          : PXSC_MODE_STRAIGHT);
        return a ? PXSC_MODE_AUTO : (m ? PXSC_MODE_CROSS : PXSC_MODE_STRAIGHT);
    endfunction

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask

    task automatic check_all(input logic [15:0] r);
        logic [15:0] d;
        logic        v;
        pxsc_mode_e  e;
        e = exp_mode(r, auto_s[1], man_s[1]);
        chk("mode", 16'(e), 16'(mode));
        chk("heartbeat", 16'(!r[PXSC_BIT_HB_DIS]), 16'(hb_en));
        chk("pll", 16'(r[PXSC_BIT_PLL_REF]), 16'(pll));
        chk("rx10", 16'(rx10 && !r[PXSC_BIT_PLL_REF]), 16'(rx10_o));
        chk("hwcfg", 16'(auto_s), 16'(hwcfg));
        i_host.read_reg(PXSC_REG_INDEX, d, v);
        chk("valid", 16'h0001, 16'(v));
        chk("rdata", r | (16'(pol) << PXSC_BIT_POL_REV), d);
        i_host.read_reg(5'h1c, d, v);
        chk("stray_valid", 16'h0000, 16'(v));
    endtask

    task automatic give_verdict;
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h0220;
        {clk, rst_n, port_rst, basic_rst, pol, rx10} = '0;
        en = 1'b1;
        {auto_s, man_s} = '0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        check_all(16'h0000);
        for (int i = 0; i < 48; i++) begin
            w = $random(seed);
            if (i < 8)
                w = {i[2:0], 13'h1fff};
            if (w[14])
                w[13] = 1'b0;
            {auto_s, man_s, pol, rx10} = 6'($random(seed));
            i_host.write_reg(PXSC_REG_INDEX, w);
            i_host.write_reg(5'h1a, ~w);
            // polarity passes a synchroniser
            repeat (3) @(negedge clk);
            check_all(w & PXSC_WRITE_MASK);
        end
        // port reset without the qualifier keeps the bits
        i_host.write_reg(PXSC_REG_INDEX, 16'hcc00);
        @(negedge clk);
        port_rst = 1'b1;
        @(negedge clk);
        {port_rst, basic_rst} = 2'h1;
        @(negedge clk);
        basic_rst = 1'b0;
        check_all(16'hcc00);
        @(negedge clk);
        {port_rst, basic_rst} = 2'h3;
        @(negedge clk);
        {port_rst, basic_rst} = 2'h0;
        check_all(16'h0000);
        // a write while the clock enable is low is not taken
        en = 1'b0;
        i_host.write_reg(PXSC_REG_INDEX, 16'h8c00);
        en = 1'b1;
        check_all(16'h0000);
        // a second reset in mid-run restores the defaults
        i_host.write_reg(PXSC_REG_INDEX, 16'h8c00);
        check_all(16'h8c00);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        // polarity passes a synchroniser again
        repeat (3) @(negedge clk);
        check_all(PXSC_RESET_VALUE);
        give_verdict();
    end
endmodule // pxsc_top_bench
